// File: dlio_pkg.sv
// Purpose: Shared constants and types for the two-line I/O port.
// Assumes: 40 MHz clock, one clock domain.
// Notes: Mode and notification codes are also the port-level encodings.
package dlio_pkg;
    localparam int NUM_LINES = 2;
    localparam int MODE_W = 4;
    localparam int NOTE_W = 2;
    localparam int CLK_MHZ = 40;
    // Settling time for the power-managed sink before sampling
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int SETTLE_W = 13;

    typedef enum logic [3:0] {
        DLIO_SINK      = 4'h0,
        DLIO_SINK_PM   = 4'h1,
        DLIO_LOGIC_IN  = 4'h2,
        DLIO_CONTACT   = 4'h3,
        DLIO_DO_SINK   = 4'h4,
        DLIO_DO_SOURCE = 4'h5,
        DLIO_DO_OPENC  = 4'h6,
        DLIO_DO_PUSH   = 4'h7,
        DLIO_HOST      = 4'h8
    } dlio_mode_t;

    typedef enum logic [1:0] {
        DLIO_NOTE_OFF  = 2'h0,
        DLIO_NOTE_FALL = 2'h1,
        DLIO_NOTE_RISE = 2'h2
    } dlio_note_t;

    localparam logic [3:0] MODE_RESET = 4'h8;
    localparam logic [1:0] NOTE_RESET = 2'h0;

    // Analog controls of one pin pad
    typedef struct packed {
        logic drive_oe;   // Pad driver enabled
        logic drive_val;  // Level driven when enabled
        logic pullup_en;  // 3 V pull-up switched in
        logic sink_en;    // Low-impedance path to ground
    } dlio_pad_t;
endpackage : dlio_pkg

// File: dlio_port.sv
// Purpose: Two-line digital I/O port with per-line modes and edge flags.
// Assumes: Pad electrics are outside; control bits arrive as plain ports.
// Notes: Pins pass a three-stage synchroniser before any use.
// Summary of operation
// RL1: Mode setting is written and read back; resets to host-deferred.
// RL2: Host-deferred mode uses the host supplied mode instead.
// RL3: Sink-only output: 1 leaves line floating, 0 drives low.
// RL4: Source-only output: 1 drives high to supply, 0 floats.
// RL5: Open-collector: 1 releases to 3 V pull-up, 0 drives low.
// RL6: Push-pull: 1 drives high, 0 drives low.
// RL7: Push-pull without line supply acts as sink-only.
// RL8: Each line has a readable notification flag.
// RL9: Notification setting off, falling or rising; resets to off.
// RL10: Contact-closure mode enables pull-up while sampling.
// RL11: Notifications off and no read: contact pull-up switched off.
// RL12: Notifications off and no read: power-managed sink path removed.
// RL13: Edge notification on: sample continuously, bias always on.
// RL14: External driver settles within 100 us after sink applied.
// RL15: Plain sinking mode keeps the sink path on permanently.
// RL16: Logic input mode is high impedance, no pull-up, no sink.
// RL17: Synchronised input edge sets the flag; reading clears it.
// RL18: Each line has independent mode, notification, output and flag.
module dlio_port #(
    parameter int LINES = dlio_pkg::NUM_LINES,
    parameter int SETTLE_CYCLES = dlio_pkg::SETTLE_CYC
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [LINES-1:0] i_mode_wr,
    input wire logic [dlio_pkg::MODE_W-1:0] i_mode_wdata,
    output logic [LINES*dlio_pkg::MODE_W-1:0] o_mode_rdata,
    input wire logic [LINES*dlio_pkg::MODE_W-1:0] i_host_mode,
    input wire logic [LINES-1:0] i_note_wr,
    input wire logic [dlio_pkg::NOTE_W-1:0] i_note_wdata,
    output logic [LINES*dlio_pkg::NOTE_W-1:0] o_note_rdata,
    input wire logic [LINES-1:0] i_out_wr,
    input wire logic i_out_wdata,
    output logic [LINES-1:0] o_out_rdata,
    input wire logic i_read_req,
    output logic o_read_ready,
    output logic [LINES-1:0] o_in_value,
    input wire logic [LINES-1:0] i_flag_rd,
    output logic [LINES-1:0] o_flag,
    input wire logic i_line_supply_present,
    input wire logic [LINES-1:0] i_pin,
    output logic [LINES-1:0] o_pin,
    output logic [LINES-1:0] o_pin_oe,
    output logic [LINES-1:0] o_pullup_en,
    output logic [LINES-1:0] o_sink_en,
    output logic [LINES*dlio_pkg::MODE_W-1:0] o_eff_mode
);
    localparam int MW = dlio_pkg::MODE_W;
    localparam int NW = dlio_pkg::NOTE_W;
    localparam int CW = dlio_pkg::SETTLE_W;
    // A pin sample needs four edges to reach in_q; the wait is stretched so
    // the captured level was taken a full settling time after bias came on
    localparam int SYNC_LAG = 4;
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES + SYNC_LAG - 1);

    logic [MW-1:0] mode_q [LINES];
    logic [NW-1:0] note_q [LINES];
    logic [LINES-1:0] out_q;
    logic [LINES-1:0] flag_q;
    logic [LINES-1:0] s1_q, s2_q, s3_q;
    logic [LINES-1:0] in_q;
    logic [LINES-1:0] hist_q;
    logic [LINES-1:0] in_d;
    logic [CW-1:0] settle_q;
    logic reading_q;
    logic rd_ready_q;
    logic [LINES-1:0] active;
    dlio_pkg::dlio_pad_t pad [LINES];
    logic [MW-1:0] eff [LINES];

    // Effective mode: host setting replaces the local one when deferred
    function automatic logic [MW-1:0] pick_mode(input logic [MW-1:0] loc,
                                               input logic [MW-1:0] host);
        if (loc == dlio_pkg::MODE_RESET)
            return host; // see RL2
        return loc;
    endfunction : pick_mode

    // Pad controls for one line from mode, output value and activity
    function automatic dlio_pkg::dlio_pad_t pad_of(input logic [MW-1:0] m,
                                                  input logic v,
                                                  input logic act,
                                                  input logic sup);
        dlio_pkg::dlio_pad_t p;
        p = '0;
        unique case (dlio_pkg::dlio_mode_t'(m))
            dlio_pkg::DLIO_SINK:      p.sink_en = 1'b1; // see RL15
            dlio_pkg::DLIO_SINK_PM:   p.sink_en = act; // see RL12
            dlio_pkg::DLIO_LOGIC_IN:  p = '0; // see RL16
            dlio_pkg::DLIO_CONTACT:   p.pullup_en = act; // see RL10 RL11
            dlio_pkg::DLIO_DO_SINK:   p.drive_oe = ~v; // see RL3
            dlio_pkg::DLIO_DO_SOURCE:
            begin
                p.drive_oe = v; // see RL4
                p.drive_val = 1'b1;
            end
            dlio_pkg::DLIO_DO_OPENC:
            begin
                p.drive_oe = ~v; // see RL5
                p.pullup_en = v;
            end
            dlio_pkg::DLIO_DO_PUSH:
            begin
                p.drive_oe = ~v | sup; // see RL6 RL7
                p.drive_val = v & sup;
            end
            default:  p = '0; // Host code undefined or unknown: stay passive
        endcase
        return p;
    endfunction : pad_of

    // Local settings, one set per line
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < LINES; i++)
            begin
                mode_q[i] <= dlio_pkg::MODE_RESET; // see RL1
                note_q[i] <= dlio_pkg::NOTE_RESET; // see RL9
            end
            out_q <= '0;
        end
        else
        begin
            for (int i = 0; i < LINES; i++)
            begin
                if (i_mode_wr[i])
                    mode_q[i] <= i_mode_wdata; // see RL1 RL18
                if (i_note_wr[i] && i_note_wdata != 2'h3)
                    note_q[i] <= i_note_wdata; // see RL9
                if (i_out_wr[i])
                    out_q[i] <= i_out_wdata;
            end
        end
    end

    // Three-stage pin synchroniser; only stages two and three are compared
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered level only moves when stages two and three agree
    always_comb
    begin
        for (int i = 0; i < LINES; i++)
            in_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : in_q[i];
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            in_q <= '0;
            hist_q <= '0;
        end
        else
        begin
            in_q <= in_d;
            hist_q <= in_q; // see RL17
        end
    end

    // Sampling is active while a read runs or edges are watched
    always_comb
    begin
        for (int i = 0; i < LINES; i++)
        begin
            active[i] = reading_q || note_q[i] != dlio_pkg::NOTE_RESET; // see RL13
            eff[i] = pick_mode(mode_q[i], i_host_mode[i*MW +: MW]);
            pad[i] = pad_of(eff[i], out_q[i], active[i],
                            i_line_supply_present);
        end
    end

    // Read sequence: bias on, wait for settling, then capture.
    // The wait covers slow power-managed drivers at the price of latency.
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            reading_q <= 1'b0;
            settle_q <= '0;
            rd_ready_q <= 1'b0;
            o_in_value <= '0;
        end
        else
        begin
            rd_ready_q <= 1'b0;
            if (!reading_q && i_read_req)
            begin
                reading_q <= 1'b1;
                settle_q <= '0;
            end
            else if (reading_q && settle_q == SETTLE_LAST)
            begin
                reading_q <= 1'b0; // see RL14
                rd_ready_q <= 1'b1;
                o_in_value <= in_q;
            end
            else if (reading_q)
                settle_q <= settle_q + 1'b1;
        end
    end

    // Edge flags: a new edge wins over a clear in the same cycle
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
            flag_q <= '0;
        else
        begin
            for (int i = 0; i < LINES; i++)
            begin
                if ((note_q[i] == dlio_pkg::DLIO_NOTE_FALL
                        && hist_q[i] && !in_q[i])
                    || (note_q[i] == dlio_pkg::DLIO_NOTE_RISE
                        && !hist_q[i] && in_q[i]))
                    flag_q[i] <= 1'b1; // see RL17 RL8
                else if (i_flag_rd[i])
                    flag_q[i] <= 1'b0; // see RL17
            end
        end
    end

    // Port packing
    always_comb
    begin
        for (int i = 0; i < LINES; i++)
        begin
            o_mode_rdata[i*MW +: MW] = mode_q[i];
            o_note_rdata[i*NW +: NW] = note_q[i];
            o_eff_mode[i*MW +: MW] = eff[i];
            o_pin[i] = pad[i].drive_val;
            o_pin_oe[i] = pad[i].drive_oe;
            o_pullup_en[i] = pad[i].pullup_en;
            o_sink_en[i] = pad[i].sink_en;
        end
    end
    assign o_out_rdata = out_q;
    assign o_flag = flag_q;
    assign o_read_ready = rd_ready_q;

    // Flag rises only when notification was enabled in the cycle before
    a_flag_cause: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(flag_q[0]) |-> $past(note_q[0] != 2'h0)) // see RL17
        else $error("flag set without enabled edge");
    a_mode_read: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_mode_wr[0] |=> o_mode_rdata[MW-1:0] == $past(i_mode_wdata)) // see RL1
        else $error("mode write not read back");
    a_host_mode: assert property (@(posedge i_mclk) disable iff (i_reset)
        mode_q[0] == 4'h8 |-> eff[0] == i_host_mode[MW-1:0]) // see RL2
        else $error("host mode not used");
    a_push_nosup: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h7 && !i_line_supply_present |-> !o_pin[0]
        && o_pin_oe[0] == !out_q[0]) // see RL7
        else $error("push-pull drove high without supply");
    a_sink_plain: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h0 |-> o_sink_en[0] && !o_pin_oe[0]) // see RL15
        else $error("plain sink path off");
    a_logic_hiz: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[1] == 4'h2 |-> !o_sink_en[1] && !o_pullup_en[1]
        && !o_pin_oe[1]) // see RL16
        else $error("logic input not high impedance");
    a_pm_idle_off: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h1 && note_q[0] == 2'h0 && !reading_q
        |-> !o_sink_en[0]) // see RL12
        else $error("power-managed sink left on");
    a_edge_bias: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h3 && note_q[0] != 2'h0 |-> o_pullup_en[0]) // see RL13
        else $error("bias off while watching edges");
    a_read_settle: assert property (@(posedge i_mclk) disable iff (i_reset)
        !reading_q && i_read_req |=> reading_q [*8]) // see RL14
        else $error("read finished before settling");
    a_sink_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h4 |-> o_pin_oe[0] == !out_q[0] && !o_pin[0]) // see RL3
        else $error("sink-only output drove wrong level");
    a_source_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h5 |-> o_pin_oe[0] == out_q[0] && o_pin[0]) // see RL4
        else $error("source-only output drove wrong level");
    a_open_coll: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h6 |-> o_pullup_en[0] == out_q[0]
        && o_pin_oe[0] == !out_q[0] && !o_pin[0]) // see RL5
        else $error("open-collector output wrong");
    a_push_sup: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h7 && i_line_supply_present
        |-> o_pin_oe[0] && o_pin[0] == out_q[0]) // see RL6
        else $error("push-pull output wrong with supply");
    a_contact_read: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h3 && reading_q |-> o_pullup_en[0]) // see RL10
        else $error("contact pull-up off during read");
    a_contact_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
        eff[0] == 4'h3 && note_q[0] == 2'h0 && !reading_q
        |-> !o_pullup_en[0]) // see RL11
        else $error("contact pull-up left on");
    a_flag_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_flag[0] && !i_flag_rd[0] |=> o_flag[0]) // see RL8
        else $error("flag lost without a read");
endmodule : dlio_port

// File: dlio_field.sv
// Purpose: Field devices on the two pins.
// Assumes: Pad controls per line from the port.
// Notes: A line with no driver and no bias toggles each clock, never holds.
module dlio_field (
    input wire logic i_clk,
    input wire logic [1:0] i_oe,
    input wire logic [1:0] i_val,
    input wire logic [1:0] i_pullup,
    input wire logic [1:0] i_sink,
    input wire logic [1:0] i_drv_en,
    input wire logic [1:0] i_drv_val,
    output logic [1:0] o_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] flt_q = 2'h0;
    // Floating pattern so an open line never reads stable
    always @(posedge i_clk)
        flt_q <= ~flt_q;
    // Pad first, then outside driver valid at once, then bias
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (i_oe[k])
                o_line[k] = i_val[k];
            else if (i_drv_en[k])
                o_line[k] = i_drv_val[k];
            else if (i_pullup[k])
                o_line[k] = 1'b1;
            else if (i_sink[k])
                o_line[k] = 1'b0;
            else
                o_line[k] = flt_q[k];
        end
    end
endmodule : dlio_field

// File: dual_line_io_with_edge_events_tb.sv
// Purpose: Self-checking bench for the two-line port.
// Assumes: Settle count cut to 8 cycles to keep the run short.
// Notes: Inputs change 1 ns after the rising edge.
module dual_line_io_with_edge_events_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, sup = 1'b0, rreq = 1'b0;
    logic [1:0] mwr = 2'h0, nwr = 2'h0, owr = 2'h0, frd = 2'h0;
    logic [3:0] mwd = 4'h0;
    logic [1:0] nwd = 2'h0, dren = 2'h3, drv = 2'h3;
    logic owd = 1'b0;
    logic [7:0] host = 8'h27, mrd, eff;
    logic [3:0] nrd;
    logic [1:0] ord, inv, flg, pin, po, poe, pu, sk;
    logic rdy;
    int mismatches = 0, checked = 0;
    localparam int SETTLE = 8;
    // Clock at 40 MHz
    initial forever #12.5 clk = ~clk;
    dlio_port #(.SETTLE_CYCLES(SETTLE)) uut (.i_mclk(clk), .i_reset(rst),
        .i_mode_wr(mwr), .i_mode_wdata(mwd), .o_mode_rdata(mrd),
        .i_host_mode(host), .i_note_wr(nwr), .i_note_wdata(nwd),
        .o_note_rdata(nrd), .i_out_wr(owr), .i_out_wdata(owd),
        .o_out_rdata(ord), .i_read_req(rreq), .o_read_ready(rdy),
        .o_in_value(inv), .i_flag_rd(frd), .o_flag(flg),
        .i_line_supply_present(sup), .i_pin(pin), .o_pin(po),
        .o_pin_oe(poe), .o_pullup_en(pu), .o_sink_en(sk),
        .o_eff_mode(eff));
    dlio_field fld (.i_clk(clk), .i_oe(poe), .i_val(po), .i_pullup(pu),
        .i_sink(sk), .i_drv_en(dren), .i_drv_val(drv), .o_line(pin));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Strobe then one idle edge, so no signal is set twice in a step
    task automatic wr_mode(input int l, input logic [3:0] c);
        mwr = 2'h1 << l; mwd = c; tick(1); mwr = 2'h0; tick(1);
    endtask : wr_mode
    task automatic wr_note(input int l, input logic [1:0] c);
        nwr = 2'h1 << l; nwd = c; tick(1); nwr = 2'h0; tick(1);
    endtask : wr_note
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic t_reset;
        chk(mrd, 8'h88);
        chk({4'h0, nrd}, 8'h00);
        chk({6'h0, flg}, 8'h00);
        chk(eff, host);
    endtask : t_reset
    // Drive styles over every value and supply state
    task automatic t_out;
        logic [2:0] e;
        for (int m = 4; m < 8; m++)
        begin
            wr_mode(0, m[3:0]);
            chk({4'h0, mrd[3:0]}, m);
            chk({4'h0, eff[7:4]}, 8'h02);
            for (int s = 0; s < 2; s++)
                for (int v = 0; v < 2; v++)
                begin
                    sup = s[0]; owr = 2'h1; owd = v[0]; tick(1);
                    owr = 2'h0; tick(1);
                    chk({6'h0, ord}, {7'h0, v[0]});
                    e = 3'h0;
                    if (m == 4 || m == 6 || (m == 7 && s == 0))
                        e = {~v[0], 1'b0, m == 6 && v == 1};
                    else
                        e = {m == 7 || v == 1, v[0], 1'b0};
                    chk({poe[0], poe[0] & po[0], pu[0]}, e); // 7
                end
        end
        // Rewriting the deferred code must hand control back to the host
        wr_mode(0, 4'h8);
        chk(eff, host);
    endtask : t_out
    // Bias idle, during a read, after it, and with edges enabled
    task automatic t_bias;
        logic [1:0] idl [4] = '{2'h1, 2'h0, 2'h0, 2'h0};
        logic [1:0] act [4] = '{2'h1, 2'h1, 2'h0, 2'h2};
        int w;
        drv = 2'h1;
        for (int m = 0; m < 4; m++)
        begin
            wr_mode(0, m[3:0]);
            chk({pu[0], sk[0]}, idl[m]);
            rreq = 1'b1; tick(1); rreq = 1'b0; tick(1);
            chk({pu[0], sk[0]}, act[m]);
            w = 0;
            while (rdy !== 1'b1 && w < 20)
            begin
                tick(1);
                w++;
            end
            // Ready may not come before the full settling count
            chk(w >= SETTLE - 1 && w < 20, 1'b1);
            chk(inv, 2'h1);
            tick(1);
            chk({pu[0], sk[0]}, idl[m]);
        end
        wr_note(0, 2'h1);
        wr_mode(0, 4'h1);
        tick(4);
        chk(sk[0], 1'b1);
        wr_mode(0, 4'h3);
        chk(pu[0], 1'b1);
        wr_note(0, 2'h3);
        chk(nrd[1:0], 2'h1);
        wr_note(0, 2'h0);
    endtask : t_bias
    // Falling edge on line 0, rising edge on line 1
    task automatic t_edge;
        wr_mode(0, 4'h2);
        wr_mode(1, 4'h2);
        drv = 2'h3; tick(6);
        wr_note(0, 2'h1);
        wr_note(1, 2'h2);
        chk({4'h0, nrd}, 8'h09);
        drv = 2'h0; tick(8);
        chk(flg, 2'h1);
        frd = 2'h1; tick(1); frd = 2'h0; tick(1);
        chk(flg, 2'h0);
        drv = 2'h3; tick(8);
        chk(flg, 2'h2);
    endtask : t_edge
    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end
    initial
    begin
        tick(16);
        rst = 1'b0;
        tick(1);
        t_reset();
        t_out();
        t_bias();
        t_edge();
        conclude();
    end
endmodule : dual_line_io_with_edge_events_tb
